// ### hw/low_freq_interval_timer.sv
/*
  low-frequency interval timer: apb registers, counter, sticky interrupt.
  assumes the slow clock and mode signals are asynchronous pins.
*/
// What this block does
// - select code picks 2^15 down to 2^8
// - run bit starts counter on slow clock
// - interval reached raises irq, keeps counting
// - clearing run zeroes and stops counter
// - select writes ignored while running
// - start write may load select; stop keeps
// - oscillator off or stop/sleep0 clears run
// - clock gate zero makes block unusable
// - reset clears run, select and gate
// - operates only while slow clock runs
`timescale 1ns/1ps
module low_freq_interval_timer (
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [13:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_LOW_FREQ_CLOCK,
  input wire logic I_SLOW_OSC_ENABLE,
  input wire logic I_STOP_MODE,
  input wire logic I_SLEEP0_MODE,
  output logic O_INTERVAL_IRQ
);
  interval_timer_pkg::apb_req_t req; // bundled bus inputs
  interval_timer_pkg::ctrl_t ctrl_q, ctrl_d; // run and select
  logic [7:0] gate_q, gate_d; // clock gate register
  logic [interval_timer_pkg::CNT_W-1:0] cnt_q, cnt_d; // binary counter
  logic stat_q, stat_d; // sticky interval event
  logic mask_q, mask_d; // interrupt enable
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d;
  logic err_q, err_d;
  logic irq_q, irq_d;
  logic [2:0] osc_s, stop_s, sleep_s; // two-flop synchronisers plus held stage
  logic slow_rise; // one-cycle enable per slow clock rising edge
  logic access; // apb access phase
  logic wr, rd;
  logic mapped;
  logic hit; // interval reached this slow tick
  logic force_off; // power-down condition
  logic gate_on;
  logic [interval_timer_pkg::CNT_W-1:0] limit; // last count of the period

  assign req = '{sel: I_PSEL, enable: I_PENABLE, write: I_PWRITE, addr: I_PADDR, wdata: I_PWDATA};

  // slow clock becomes an enable pulse in the reference domain
  slow_clock_sync u_sync (
    .i_clk(I_REF_CLK),
    .i_nrst(I_NRST),
    .i_async(I_LOW_FREQ_CLOCK),
    .o_rise(slow_rise)
  );

  // mode pins pass three flops before use; stage 2 is the usable copy
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      osc_s <= 3'h0;
      stop_s <= 3'h0;
      sleep_s <= 3'h0;
    end else begin
      osc_s <= {osc_s[1:0], I_SLOW_OSC_ENABLE};
      stop_s <= {stop_s[1:0], I_STOP_MODE};
      sleep_s <= {sleep_s[1:0], I_SLEEP0_MODE};
    end
  end

  // decode; one wait state, pready rises on the second access cycle
  // writes land only at the edge where the master sees pready high
  always_comb begin
    access = req.sel & req.enable & ~ready_q;
    mapped = (req.addr == interval_timer_pkg::OFF_CLOCK_GATE) || (req.addr == interval_timer_pkg::OFF_CONTROL) ||
             (req.addr == interval_timer_pkg::OFF_IRQ_STATUS) || (req.addr == interval_timer_pkg::OFF_IRQ_MASK);
    wr = req.sel & req.enable & ready_q & req.write & mapped;
    rd = access & ~req.write;
    gate_on = gate_q[interval_timer_pkg::GATE_BIT];
    // oscillator stopped, stop mode or sleep0 mode
    force_off = ~osc_s[2] | stop_s[2] | sleep_s[2];
  end

  // interval limit from the select code
  always_comb begin
    limit = '0;
    case (ctrl_q.sel)
      3'h0: limit = 15'h7fff;
      3'h1: limit = 15'h3fff;
      3'h2: limit = 15'h1fff;
      3'h3: limit = 15'h0fff;
      3'h4: limit = 15'h07ff;
      3'h5: limit = 15'h03ff;
      3'h6: limit = 15'h01ff;
      3'h7: limit = 15'h00ff;
      default: limit = 15'h7fff;
    endcase
    hit = ctrl_q.run & gate_on & slow_rise & (cnt_q == limit);
  end

  // control state next values
  always_comb begin
    ctrl_d = ctrl_q;
    gate_d = gate_q;
    mask_d = mask_q;
    if (wr && req.addr == interval_timer_pkg::OFF_CLOCK_GATE) begin
      gate_d = req.wdata[7:0];
    end
    if (wr && req.addr == interval_timer_pkg::OFF_CONTROL && gate_on) begin
      if (!ctrl_q.run && req.wdata[interval_timer_pkg::RUN_BIT]) begin
        ctrl_d.sel = req.wdata[interval_timer_pkg::SEL_LSB +: 3];
      end
      // while running or when stopping, select keeps its value
      ctrl_d.run = req.wdata[interval_timer_pkg::RUN_BIT];
    end
    if (wr && req.addr == interval_timer_pkg::OFF_IRQ_MASK) begin
      mask_d = req.wdata[0];
    end
    if (force_off) begin
      ctrl_d.run = 1'h0;
    end
  end

  // counter and sticky status
  always_comb begin
    cnt_d = cnt_q;
    if (!ctrl_q.run || !gate_on) begin
      cnt_d = '0;
    end else if (slow_rise) begin
      cnt_d = (cnt_q == limit) ? '0 : cnt_q + 1'b1;
    end
    stat_d = stat_q;
    if (wr && req.addr == interval_timer_pkg::OFF_IRQ_STATUS && req.wdata[0]) begin
      stat_d = 1'h0;
    end
    if (hit) begin
      stat_d = 1'h1;
    end
    irq_d = stat_d & mask_d;
  end

  // read data and bus answer
  always_comb begin
    rdata_d = 32'h0;
    ready_d = access;
    err_d = access & ~mapped;
    if (rd) begin
      case (req.addr)
        interval_timer_pkg::OFF_CLOCK_GATE: rdata_d = {24'h0, gate_q};
        interval_timer_pkg::OFF_CONTROL: rdata_d = {28'h0, ctrl_q.sel, ctrl_q.run};
        interval_timer_pkg::OFF_IRQ_STATUS: rdata_d = {31'h0, stat_q};
        interval_timer_pkg::OFF_IRQ_MASK: rdata_d = {31'h0, mask_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // registers
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      ctrl_q <= interval_timer_pkg::CONTROL_RESET[3:0];
      gate_q <= interval_timer_pkg::GATE_RESET;
      cnt_q <= '0;
      stat_q <= interval_timer_pkg::IRQ_RESET;
      mask_q <= interval_timer_pkg::IRQ_RESET;
      rdata_q <= 32'h0;
      ready_q <= 1'h0;
      err_q <= 1'h0;
      irq_q <= 1'h0;
    end else begin
      ctrl_q <= ctrl_d;
      gate_q <= gate_d;
      cnt_q <= cnt_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q <= err_d;
      irq_q <= irq_d;
    end
  end

  assign O_PRDATA = rdata_q;
  assign O_PREADY = ready_q;
  assign O_PSLVERR = err_q;
  assign O_INTERVAL_IRQ = irq_q;

  // checks
  a_stop_clears: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
    !ctrl_q.run |=> cnt_q == '0) else $error("counter not zero while stopped");
  a_sel_locked: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
    ctrl_q.run |=> ctrl_q.sel == $past(ctrl_q.sel)) else $error("select changed while running");
  a_force_off: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
    force_off |=> !ctrl_q.run) else $error("run survived power-down");
  a_hit_sets: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
    hit |=> stat_q) else $error("interval event lost");
  a_keeps_count: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
    hit && !force_off && !wr |=> ctrl_q.run && cnt_q == '0) else $error("counter stopped at interval");
  a_gate_off: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
    !gate_on && !ctrl_q.run |=> !ctrl_q.run) else $error("run set without gate");
  a_upper_zero: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
    rd && req.addr == interval_timer_pkg::OFF_CONTROL |=> O_PRDATA[31:4] == 28'h0) else $error("upper bits set");
  a_period_max: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
    ctrl_q.sel == 3'h7 |-> cnt_q <= 15'h00ff) else $error("count past interval");
  a_ready_one: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
    I_PSEL && I_PENABLE && !ready_q |=> ready_q) else $error("no answer"); 
  c_event: cover property (@(posedge I_REF_CLK) hit);
  c_start: cover property (@(posedge I_REF_CLK) $rose(ctrl_q.run));
  c_forced: cover property (@(posedge I_REF_CLK) ctrl_q.run && force_off);
endmodule : low_freq_interval_timer

// ### shared/interval_timer_pkg.sv
/*
  constants and types shared by the low-frequency interval timer design.
  assumes an apb slave with 32-bit data and one aligned word per register.
*/
package interval_timer_pkg;
  // register indices; the printed offsets are not word aligned, so each is a word index
  localparam logic [11:0] IDX_CLOCK_GATE = 12'hf76; // peripheral_clock_gate_two
  localparam logic [11:0] IDX_CONTROL = 12'hfc8; // interval_timer_control
  localparam logic [11:0] IDX_IRQ_STATUS = 12'hfc9; // sticky event bits
  localparam logic [11:0] IDX_IRQ_MASK = 12'hfca; // event enables
  // byte addresses on the apb window: four times the index
  localparam int ADDR_W = 14;
  localparam logic [13:0] OFF_CLOCK_GATE = {IDX_CLOCK_GATE, 2'h0};
  localparam logic [13:0] OFF_CONTROL = {IDX_CONTROL, 2'h0};
  localparam logic [13:0] OFF_IRQ_STATUS = {IDX_IRQ_STATUS, 2'h0};
  localparam logic [13:0] OFF_IRQ_MASK = {IDX_IRQ_MASK, 2'h0};
  // field positions
  localparam int GATE_BIT = 5; // interval_clock_gate
  localparam int SERIAL0_BIT = 0; // serial0_clock_gate, plain storage
  localparam int RUN_BIT = 0; // interval_run
  localparam int SEL_LSB = 1; // interval_select, three bits
  // reset values
  localparam logic [7:0] GATE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [0:0] IRQ_RESET = 1'h0;
  // counter width: longest interval is 2^15 slow clocks
  localparam int CNT_W = 15;
  // clock rate of the bus clock
  localparam int REF_CLK_HZ = 20000000;

  // one apb request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [13:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

  // the timer's software-visible control state
  typedef struct packed {
    logic [2:0] sel;
    logic run;
  } ctrl_t;
endpackage : interval_timer_pkg

// ### hw/slow_clock_sync.sv
/*
  synchroniser and rising-edge detector for the low-frequency clock pin.
  assumes the slow clock is far below the reference clock.
*/
`timescale 1ns/1ps
module slow_clock_sync (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_async,
  output logic o_rise
);
  logic meta_q; // first stage, read only by sync_q
  logic sync_q;
  logic last_q;
  logic rise_q;
  logic meta_d;
  logic sync_d;
  logic last_d;
  logic rise_d;

  // next values of the chain
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
    last_d = sync_q;
    rise_d = sync_q & ~last_q;
  end

  // registers, synchronous reset
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
      last_q <= 1'h0;
      rise_q <= 1'h0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
      rise_q <= rise_d;
    end
  end

  assign o_rise = rise_q;
endmodule : slow_clock_sync

// ### verification/low_freq_interval_timer_tb_top.sv
/*
  self-checking bench for the low-frequency interval timer: apb table, interval irq, forced stop, reset.
  assumes the design answers apb with its own pready and syncs the slow pins internally.
*/
`timescale 1ns/1ps
module low_freq_interval_timer_tb_top;
  // one table row: request beside expected read data and error
  typedef struct packed {logic w; logic [13:0] a; logic [31:0] d; logic [31:0] e; logic se;} row_t;
  localparam logic [13:0] GATE = interval_timer_pkg::OFF_CLOCK_GATE;
  localparam logic [13:0] CTRL = interval_timer_pkg::OFF_CONTROL;
  localparam logic [13:0] STAT = interval_timer_pkg::OFF_IRQ_STATUS;
  localparam logic [13:0] MASK = interval_timer_pkg::OFF_IRQ_MASK;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, irq;
  logic slow = 1'b0, osc = 1'b1, stp = 1'b0, slp = 1'b0; // slow clock stands still outside counting
  int err_count = 0, comparisons = 0, n;
  row_t rows [15];
  low_freq_interval_timer uut (.I_REF_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_LOW_FREQ_CLOCK(slow), .I_SLOW_OSC_ENABLE(osc), .I_STOP_MODE(stp),
    .I_SLEEP0_MODE(slp), .O_INTERVAL_IRQ(irq));
  // 20 mhz reference
  always #25 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // irq is registered after the write edge, so look at it mid-cycle
  task automatic chk_irq(input logic e);
    @(negedge clk);
    check({31'h0, irq}, {31'h0, e});
  endtask : chk_irq
  task automatic tally_and_finish;
    if (err_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // setup then access, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb
  // each edge is two reference cycles high, three low
  task automatic edges(input int k);
    repeat (k) begin
      @(posedge clk) slow <= 1'b1;
      repeat (2) @(posedge clk);
      slow <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (6) @(posedge clk); // let sync and irq register settle
  endtask : edges
  // a hang counts as a failure
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    rows = '{'{0, GATE, 0, 0, 0}, '{0, CTRL, 0, 0, 0},
      '{1, CTRL, 32'h0f, 0, 0}, '{0, CTRL, 0, 0, 0}, // control refused while gate off
      '{1, GATE, 32'hff, 0, 0}, '{0, GATE, 0, 32'hff, 0}, '{1, GATE, 32'h20, 0, 0},
      '{1, CTRL, 32'h0f, 0, 0}, '{0, CTRL, 0, 32'h0f, 0},
      '{1, CTRL, 32'hf5, 0, 0}, '{0, CTRL, 0, 32'h0f, 0},
      '{1, CTRL, 32'h04, 0, 0}, '{0, CTRL, 0, 32'h0e, 0}, // stop keeps select
      '{0, 14'h0000, 0, 0, 1}, '{1, MASK, 32'h1, 0, 0}};
    // gate stays set from here on while the timer runs
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) check(rd, rows[i].e);
      check({31'h0, er}, {31'h0, rows[i].se});
    end
    for (int s = 7; s >= 6; s--) begin
      n = 1 << (15 - s);
      apb(1, STAT, 32'h1);
      apb(1, CTRL, 32'(s * 2 + 1));
      edges(n - 1);
      chk_irq(1'b0);
      edges(1);
      chk_irq(1'b1);
      apb(1, MASK, 32'h0);
      chk_irq(1'b0);
      apb(1, MASK, 32'h1);
      apb(1, STAT, 32'h1);
      chk_irq(1'b0);
      edges(n);
      chk_irq(1'b1); // keeps counting
      edges(n / 2);
      apb(1, CTRL, 32'h0);
      apb(1, STAT, 32'h1);
      apb(1, CTRL, 32'(s * 2 + 1));
      edges(n - 1);
      chk_irq(1'b0); // counter restarted from zero
      apb(1, CTRL, 32'h0);
    end
    for (int k = 0; k < 3; k++) begin
      apb(1, CTRL, 32'h0f);
      @(posedge clk) begin osc <= (k != 0); stp <= (k == 1); slp <= (k == 2); end
      repeat (6) @(posedge clk);
      osc <= 1'b1; stp <= 1'b0; slp <= 1'b0;
      repeat (6) @(posedge clk);
      apb(0, CTRL, 0);
      check(rd, 32'h0e);
    end
    apb(1, CTRL, 32'h0f);
    @(posedge clk) nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    apb(0, GATE, 0);
    check(rd, 32'h0);
    apb(0, CTRL, 0);
    check(rd, 32'h0);
    tally_and_finish();
  end
endmodule : low_freq_interval_timer_tb_top
